// [hdl/motor_drive_cfg.svh]
/*
 Offsets, reset values, step times in ns and scale constants of the duty and lead control.
 Assumes a 100 MHz core clock and word-aligned register offsets.
*/
`ifndef MOTOR_DRIVE_CFG_SVH
`define MOTOR_DRIVE_CFG_SVH
`define CLK_PERIOD_NS      10
`define DUTY_STEP_NS       2700000
`define SLOW_STEP_NS       10800000
`define OFS_LEAD_CTRL      5'h00
`define OFS_DRIVE_CTRL     5'h04
`define OFS_START_CFG      5'h08
`define OFS_SOFT_CFG       5'h0C
`define OFS_STATUS         5'h10
`define OFS_LEAD_STATUS    5'h14
`define RST_LEAD_CTRL      12'h200
`define RST_DRIVE_CTRL     11'h000
`define RST_START_FREQ     16'h000A
`define RST_START_CUR      9'h040
`define RST_SS_LIMIT       7'h08
`define RST_LOCK_ON        16'h0100
`define LEAD_CODE_MAX      5'd27
`define LEAD_MULT          4'd15
`define LEAD_SHIFT         9
`define LEAD_MAX_Q6        12'd3720
`define LEAD_FIX0_Q6       12'd480
`define LEAD_FIX1_Q6       12'd960
`define LEAD_FIX2_Q6       12'd1440
`define LEAD_FIX3_Q6       12'd1920
`define AUTO_MAX_Q6        12'd1920
`define LOCK_MULT_LONG     3'd5
`define DUTY_FULL          13'h1000
`define SS_FREQ_BEGIN      16'h0001
`define SS_FREQ_STEP       16'h0001
`define RPM_PER_HZ         6'd60
`endif

// [hdl/motor_drive_pkg.sv]
/*
 Types of the duty and lead control: states, operating phases and register layouts.
 Assumes the constants header is compiled alongside.
*/
package motor_drive_pkg;
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_SOFT = 3'b010,
        ST_RUN  = 3'b100
    } run_state_e;
    typedef enum logic [2:0] {
        PH_STEADY  = 3'h0,
        PH_ACCEL   = 3'h1,
        PH_DECEL   = 3'h2,
        PH_OPEN    = 3'h3,
        PH_MILD    = 3'h4,
        PH_REVERSE = 3'h5
    } op_phase_e;
    typedef struct packed {
        logic       slow_period;
        logic [2:0] duty_slew_limit;
        logic       ss_lock_long;
        logic       comm_150;
        logic       auto_lead_disable;
        logic [4:0] lead_angle_table_code;
    } lead_ctrl_s;
    typedef struct packed {
        logic [2:0] speed_step_limit;
        logic [3:0] gate_sink_current_code;
        logic [3:0] gate_source_current_code;
    } drive_ctrl_s;
    typedef struct packed {
        logic [10:0] source_ma_x10;
        logic [10:0] sink_ma_x10;
    } gate_drive_s;
endpackage

// [hdl/motor_drive_duty_lead_control.sv]
/*
 Duty slew, soft start, lead angle, gate current and speed step control of a
 single-Hall fan motor pre-driver, with a plain register port.
 Assumes speed, current and duty commands come from logic on core_clk; the Hall
 and current zero-cross levels arrive from pins and are synchronised here.
*/
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "motor_drive_cfg.svh"
module motor_drive_duty_lead_control #(
    parameter logic [19:0] TICK_CYCLES = 20'(`DUTY_STEP_NS / `CLK_PERIOD_NS)
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic [4:0]                 reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output      logic [31:0]                reg_rdata,
    input  wire logic                       hall_pin,
    input  wire logic                       cur_zc_pin,
    input  wire logic                       run_cmd,
    input  wire motor_drive_pkg::op_phase_e op_phase,
    input  wire logic [15:0]                motor_rpm,
    input  wire logic [8:0]                 out_current,
    input  wire logic [8:0]                 duty_cmd,
    input  wire logic [15:0]                target_rpm_req,
    output      logic [9:0]                 duty_out,
    output      logic [12:0]                lead_angle_q6,
    output      logic [15:0]                cmd_freq_hz,
    output      logic [15:0]                target_rpm,
    output      logic                       soft_active,
    output      logic                       lock_fault,
    output      logic                       comm_150,
    output      motor_drive_pkg::gate_drive_s gate_drive
);
    localparam logic [2:0] SLOW_RATIO = 3'(`SLOW_STEP_NS / `DUTY_STEP_NS);

    motor_drive_pkg::lead_ctrl_s  lead_ctrl_ff;
    motor_drive_pkg::drive_ctrl_s drive_ctrl_ff;
    motor_drive_pkg::run_state_e  state_ff;
    motor_drive_pkg::run_state_e  nxt_state;
    logic [15:0] start_freq_ff;
    logic [8:0]  start_cur_ff;
    logic [6:0]  ss_limit_ff;
    logic [15:0] lock_on_ff;
    logic [1:0]  sync1_ff;
    logic [1:0]  sync2_ff;
    logic [1:0]  sync3_ff;
    logic [1:0]  filt_ff;
    logic [1:0]  filt_d_ff;
    logic        hall_edge;
    logic        zc_edge;
    logic [19:0] tick_cnt_ff;
    logic        tick;
    logic [2:0]  slow_cnt_ff;
    logic        slow_tick;
    logic [23:0] hall_cnt_ff;
    logic [23:0] hall_period_ff;
    logic [11:0] auto_lead_ff;
    logic        auto_active;
    logic [21:0] start_rpm;
    logic [24:0] lead_prod;
    logic [15:0] lead_raw;
    logic [11:0] table_lead;
    logic [18:0] lock_limit;
    logic [18:0] lock_ticks_ff;
    logic [12:0] duty_ff;
    logic [6:0]  slew_step;
    logic        run_step;
    logic [15:0] freq_ff;
    logic        fault_ff;
    logic [15:0] tgt_rpm_ff;
    logic [15:0] rpm_step;
    logic [31:0] rdata_ff;

    function automatic logic [12:0] step_toward(input logic [12:0] cur,
                                               input logic [12:0] tgt,
                                               input logic [6:0]  lim);
        logic [12:0] diff;
        diff = 13'h0000;
        if (tgt > cur) begin
            diff = tgt - cur;
            step_toward = (diff > {6'h00, lim}) ? cur + {6'h00, lim} : tgt;
        end else begin
            diff = cur - tgt;
            step_toward = (diff > {6'h00, lim}) ? cur - {6'h00, lim} : tgt;
        end
    endfunction

    // Register writes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lead_ctrl_ff  <= `RST_LEAD_CTRL;
            drive_ctrl_ff <= `RST_DRIVE_CTRL;
            start_freq_ff <= `RST_START_FREQ;
            start_cur_ff  <= `RST_START_CUR;
            ss_limit_ff   <= `RST_SS_LIMIT;
            lock_on_ff    <= `RST_LOCK_ON;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_LEAD_CTRL: begin
                    lead_ctrl_ff <= reg_wdata[11:0];
                end
                `OFS_DRIVE_CTRL: begin
                    drive_ctrl_ff <= {reg_wdata[10:8], 1'b0, reg_wdata[6:4],
                                      1'b0, reg_wdata[2:0]};
                end
                `OFS_START_CFG: begin
                    start_freq_ff <= reg_wdata[15:0];
                    start_cur_ff  <= reg_wdata[24:16];
                end
                `OFS_SOFT_CFG: begin
                    ss_limit_ff <= reg_wdata[6:0];
                    lock_on_ff  <= reg_wdata[23:8];
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads, data valid in the following cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_LEAD_CTRL:   rdata_ff <= {20'h0_0000, lead_ctrl_ff};
                `OFS_DRIVE_CTRL:  rdata_ff <= {21'h00_0000, drive_ctrl_ff};
                `OFS_START_CFG:   rdata_ff <= {7'h00, start_cur_ff, start_freq_ff};
                `OFS_SOFT_CFG:    rdata_ff <= {8'h00, lock_on_ff, 1'b0, ss_limit_ff};
                `OFS_STATUS:      rdata_ff <= {12'h000, duty_ff, 3'h0, fault_ff,
                                               state_ff};
                `OFS_LEAD_STATUS: rdata_ff <= {3'h0, freq_ff, lead_angle_q6};
                default:          rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_ff;

    // Pin synchronisers: bit 0 Hall, bit 1 current zero cross
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sync1_ff  <= 2'h0;
            sync2_ff  <= 2'h0;
            sync3_ff  <= 2'h0;
            filt_ff   <= 2'h0;
            filt_d_ff <= 2'h0;
        end else begin
            sync1_ff  <= {cur_zc_pin, hall_pin};
            sync2_ff  <= sync1_ff;
            sync3_ff  <= sync2_ff;
            filt_d_ff <= filt_ff;
            for (int i = 0; i < 2; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    filt_ff[i] <= sync3_ff[i];
                end
            end
        end
    end
    assign hall_edge = filt_ff[0] ^ filt_d_ff[0];
    assign zc_edge   = filt_ff[1] ^ filt_d_ff[1];

    // Duty update time base
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tick_cnt_ff <= 20'h0_0000;
            slow_cnt_ff <= 3'h0;
        end else if (tick) begin
            tick_cnt_ff <= 20'h0_0000;
            slow_cnt_ff <= (slow_cnt_ff == SLOW_RATIO - 3'h1) ? 3'h0 : slow_cnt_ff + 3'h1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 20'h0_0001;
        end
    end
    assign tick      = (tick_cnt_ff == TICK_CYCLES - 20'h0_0001);
    assign slow_tick = tick && (slow_cnt_ff == SLOW_RATIO - 3'h1);

    // Table lead angle in 1/64 degree units
    assign lead_prod = 25'(motor_rpm * `LEAD_MULT * lead_ctrl_ff.lead_angle_table_code);
    assign lead_raw  = lead_prod[24:`LEAD_SHIFT];
    always_comb begin
        table_lead = 12'h000;
        if (lead_ctrl_ff.lead_angle_table_code <= `LEAD_CODE_MAX) begin
            table_lead = (lead_raw > {4'h0, `LEAD_MAX_Q6}) ? `LEAD_MAX_Q6
                                                          : lead_raw[11:0];
        end else begin
            unique case (lead_ctrl_ff.lead_angle_table_code[1:0])
                2'h0: table_lead = `LEAD_FIX0_Q6;
                2'h1: table_lead = `LEAD_FIX1_Q6;
                2'h2: table_lead = `LEAD_FIX2_Q6;
                2'h3: table_lead = `LEAD_FIX3_Q6;
            endcase
        end
    end

    // Hall half-period measurement
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hall_cnt_ff    <= 24'h00_0000;
            hall_period_ff <= 24'hFF_FFFF;
        end else if (hall_edge) begin
            hall_cnt_ff    <= 24'h00_0000;
            hall_period_ff <= hall_cnt_ff;
        end else if (hall_cnt_ff != 24'hFF_FFFF) begin
            hall_cnt_ff <= hall_cnt_ff + 24'h00_0001;
        end
    end

    // Automatic optimizer: current crossing early in the half period means more lead
    assign start_rpm   = 22'(start_freq_ff * `RPM_PER_HZ);
    assign auto_active = !lead_ctrl_ff.auto_lead_disable
                      && ({6'h00, motor_rpm} >= start_rpm);
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            auto_lead_ff <= 12'h000;
        end else if (!auto_active) begin
            auto_lead_ff <= 12'h000;
        end else if (zc_edge) begin
            if (hall_cnt_ff < {1'b0, hall_period_ff[23:1]}) begin
                if (auto_lead_ff < `AUTO_MAX_Q6) begin
                    auto_lead_ff <= auto_lead_ff + 12'h001;
                end
            end else if (auto_lead_ff != 12'h000) begin
                auto_lead_ff <= auto_lead_ff - 12'h001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lead_angle_q6 <= 13'h0000;
        end else begin
            lead_angle_q6 <= {1'b0, auto_lead_ff} + {1'b0, table_lead};
        end
    end

    // Start sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            motor_drive_pkg::ST_STOP: begin
                if (run_cmd) begin
                    nxt_state = motor_drive_pkg::ST_SOFT;
                end
            end
            motor_drive_pkg::ST_SOFT: begin
                if (!run_cmd || (lock_ticks_ff >= lock_limit)) begin
                    nxt_state = motor_drive_pkg::ST_STOP;
                end else if (freq_ff >= start_freq_ff) begin
                    nxt_state = motor_drive_pkg::ST_RUN;
                end
            end
            motor_drive_pkg::ST_RUN: begin
                if (!run_cmd) begin
                    nxt_state = motor_drive_pkg::ST_STOP;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_ff <= motor_drive_pkg::ST_STOP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Lock supervision during soft start
    assign lock_limit = lead_ctrl_ff.ss_lock_long
                      ? 19'(lock_on_ff * `LOCK_MULT_LONG) : {3'h0, lock_on_ff};
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lock_ticks_ff <= 19'h0_0000;
        end else if (state_ff != motor_drive_pkg::ST_SOFT || hall_edge) begin
            lock_ticks_ff <= 19'h0_0000;
        end else if (tick && lock_ticks_ff != 19'h7_FFFF) begin
            lock_ticks_ff <= lock_ticks_ff + 19'h0_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fault_ff <= 1'b0;
        end else if (state_ff == motor_drive_pkg::ST_SOFT && run_cmd
                     && lock_ticks_ff >= lock_limit) begin
            fault_ff <= 1'b1;
        end else if (state_ff == motor_drive_pkg::ST_STOP && run_cmd) begin
            fault_ff <= 1'b0;
        end
    end

    // Commanded rotation frequency in soft start
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            freq_ff <= `SS_FREQ_BEGIN;
        end else if (state_ff != motor_drive_pkg::ST_SOFT) begin
            freq_ff <= `SS_FREQ_BEGIN;
        end else if (tick && freq_ff < start_freq_ff) begin
            freq_ff <= freq_ff + `SS_FREQ_STEP;
        end
    end

    // Duty slew in eighths of a 1/512 step
    always_comb begin
        unique case (lead_ctrl_ff.duty_slew_limit)
            3'h0: slew_step = 7'd64;
            3'h1: slew_step = 7'd2;
            3'h2: slew_step = 7'd3;
            3'h3: slew_step = 7'd4;
            3'h4: slew_step = 7'd6;
            3'h5: slew_step = 7'd10;
            3'h6: slew_step = 7'd20;
            3'h7: slew_step = 7'd56;
        endcase
    end
    assign run_step = (op_phase == motor_drive_pkg::PH_STEADY)
                    ? tick : (lead_ctrl_ff.slow_period ? slow_tick : tick);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            duty_ff <= 13'h0000;
        end else begin
            unique case (state_ff)
                motor_drive_pkg::ST_STOP: begin
                    duty_ff <= 13'h0000;
                end
                motor_drive_pkg::ST_SOFT: begin
                    if (tick && out_current < start_cur_ff) begin
                        duty_ff <= step_toward(duty_ff, `DUTY_FULL,
                                               ss_limit_ff);
                    end
                end
                motor_drive_pkg::ST_RUN: begin
                    if (run_step) begin
                        duty_ff <= step_toward(duty_ff, {1'b0, duty_cmd, 3'h0},
                                               slew_step);
                    end
                end
            endcase
        end
    end

    // Target speed reduction limiter
    always_comb begin
        unique case (drive_ctrl_ff.speed_step_limit)
            3'h0: rpm_step = 16'hFFFF;
            3'h1: rpm_step = 16'd512;
            3'h2: rpm_step = 16'd2200;
            3'h3: rpm_step = 16'd3800;
            3'h4: rpm_step = 16'd5400;
            3'h5: rpm_step = 16'd7000;
            3'h6: rpm_step = 16'd8600;
            3'h7: rpm_step = 16'd10240;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tgt_rpm_ff <= 16'h0000;
        end else if (target_rpm_req >= tgt_rpm_ff) begin
            tgt_rpm_ff <= target_rpm_req;
        end else if (tick) begin
            tgt_rpm_ff <= (tgt_rpm_ff - target_rpm_req > rpm_step)
                        ? tgt_rpm_ff - rpm_step : target_rpm_req;
        end
    end

    // Gate drive currents in 0.1 mA
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gate_drive <= '0;
        end else begin
            unique case (drive_ctrl_ff.gate_source_current_code[2:0])
                3'h0: gate_drive.source_ma_x10 <= 11'd100;
                3'h1: gate_drive.source_ma_x10 <= 11'd139;
                3'h2: gate_drive.source_ma_x10 <= 11'd193;
                3'h3: gate_drive.source_ma_x10 <= 11'd268;
                3'h4: gate_drive.source_ma_x10 <= 11'd373;
                3'h5: gate_drive.source_ma_x10 <= 11'd518;
                3'h6: gate_drive.source_ma_x10 <= 11'd720;
                3'h7: gate_drive.source_ma_x10 <= 11'd1000;
            endcase
            unique case (drive_ctrl_ff.gate_sink_current_code[2:0])
                3'h0: gate_drive.sink_ma_x10 <= 11'd200;
                3'h1: gate_drive.sink_ma_x10 <= 11'd278;
                3'h2: gate_drive.sink_ma_x10 <= 11'd386;
                3'h3: gate_drive.sink_ma_x10 <= 11'd537;
                3'h4: gate_drive.sink_ma_x10 <= 11'd746;
                3'h5: gate_drive.sink_ma_x10 <= 11'd1036;
                3'h6: gate_drive.sink_ma_x10 <= 11'd1439;
                3'h7: gate_drive.sink_ma_x10 <= 11'd2000;
            endcase
        end
    end

    // Registered data outputs
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            duty_out    <= 10'h000;
            cmd_freq_hz <= 16'h0000;
            comm_150    <= 1'b0;
            soft_active <= 1'b0;
        end else begin
            duty_out    <= duty_ff[12:3];
            cmd_freq_hz <= (state_ff == motor_drive_pkg::ST_SOFT) ? freq_ff : 16'h0000;
            comm_150    <= lead_ctrl_ff.comm_150;
            soft_active <= (state_ff == motor_drive_pkg::ST_SOFT);
        end
    end
    assign target_rpm = tgt_rpm_ff;
    assign lock_fault = fault_ff;
endmodule

// [test/motor_drive_duty_lead_control_checker.sv]
/*
 Port checker of the duty and lead control block.
 Assumes it is bound to every instance of that block.
*/
`timescale 1ns/100ps
module motor_drive_duty_lead_control_checker (
    input wire logic                         core_clk,
    input wire logic                         rst_b,
    input wire logic                         reg_rd,
    input wire logic [31:0]                  reg_rdata,
    input wire logic                         run_cmd,
    input wire logic [9:0]                   duty_out,
    input wire logic [12:0]                  lead_angle_q6,
    input wire logic [15:0]                  cmd_freq_hz,
    input wire logic [15:0]                  target_rpm,
    input wire logic                         soft_active,
    input wire motor_drive_pkg::gate_drive_s gate_drive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_duty_full: assert property (duty_out <= 10'h200)
        else $error("duty above full scale");
    a_stop_zero: assert property (!run_cmd [*4] |-> duty_out == 10'h000)
        else $error("duty not zero when stopped");
    a_soft_begin: assert property ($rose(soft_active) |-> cmd_freq_hz == 16'h0001)
        else $error("soft start not from one hertz");
    a_lead_cap: assert property (lead_angle_q6 <= 13'h1608)
        else $error("lead angle above limit");
    a_slew_rise: assert property (run_cmd && $past(run_cmd) |->
        duty_out <= $past(duty_out) + 10'h010)
        else $error("duty step too large");
    a_duty_hold: assert property ($changed(duty_out) ##1
        (run_cmd && $past(run_cmd)) |-> $stable(duty_out))
        else $error("duty changed between ticks");
    a_speed_down: assert property (target_rpm < $past(target_rpm) |->
        $past(target_rpm) - target_rpm <= 16'h2800)
        else $error("speed step too large");
    a_gate_table: assert property ($past(rst_b) |->
        gate_drive.source_ma_x10 inside
        {11'h064, 11'h08B, 11'h0C1, 11'h10C, 11'h175, 11'h206, 11'h2D0, 11'h3E8} &&
        gate_drive.sink_ma_x10 inside {11'h0C8, 11'h116, 11'h182, 11'h219,
        11'h2EA, 11'h40C, 11'h59F, 11'h7D0})
        else $error("gate current off table");
endmodule
bind motor_drive_duty_lead_control motor_drive_duty_lead_control_checker chk_u (
    .core_clk, .rst_b, .reg_rd, .reg_rdata, .run_cmd, .duty_out, .lead_angle_q6,
    .cmd_freq_hz, .target_rpm, .soft_active, .gate_drive);

// [test/hall_motor_model.sv]
/*
 Hall sensor and motor current zero-cross model.
 Assumes the bench clock; both lines stand still while spin is low.
*/
`timescale 1ns/100ps
module hall_motor_model #(
    parameter int HALF = 40,
    parameter int LAG  = 10
) (
    input  wire logic core_clk,
    input  wire logic spin,
    output wire logic hall_pin,
    output wire logic cur_zc_pin
);
    int   cnt_ff  = 0;
    logic hall_ff = 1'b0;
    logic zc_ff   = 1'b0;
    assign hall_pin   = hall_ff;
    assign cur_zc_pin = zc_ff;
    // Current polarity follows each Hall edge after a short lag
    always @(posedge core_clk) begin
        if (spin) begin
            cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
            if (cnt_ff == HALF - 1) hall_ff <= ~hall_ff;
            if (cnt_ff == LAG) zc_ff <= hall_ff;
        end
    end
endmodule

// [test/motor_drive_duty_lead_control_test.sv]
/*
 Self-checking bench of the duty and lead control block.
 Assumes the Hall model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module motor_drive_duty_lead_control_test;
    localparam int TK = 20;
    logic core_clk = 1'b0, rst_b, reg_wr, reg_rd, run_cmd, spin;
    logic hall_pin, cur_zc_pin, soft_active, lock_fault, comm_150;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] motor_rpm, target_rpm_req, cmd_freq_hz, target_rpm;
    logic [8:0]  out_current, duty_cmd;
    logic [9:0]  duty_out, d0;
    logic [12:0] lead_angle_q6;
    motor_drive_pkg::op_phase_e   op_phase;
    motor_drive_pkg::gate_drive_s gate_drive;
    int errors = 0, checks_done = 0, k;
    logic [4:0]  ra [5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h18};
    logic [31:0] rv [5] = '{32'h0000_0200, 32'h0000_0000, 32'h0040_000A,
                            32'h0001_0008, 32'h0000_0000};
    logic [10:0] src [8] = '{11'h064, 11'h08B, 11'h0C1, 11'h10C, 11'h175, 11'h206,
                             11'h2D0, 11'h3E8};
    logic [10:0] snk [8] = '{11'h0C8, 11'h116, 11'h182, 11'h219, 11'h2EA, 11'h40C,
                             11'h59F, 11'h7D0};
    logic [4:0]  lc [8] = '{5'h00, 5'h0E, 5'h1B, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
    logic [15:0] lr [8] = '{16'h2000, 16'h1000, 16'h1000, 16'h2000, 16'h1000,
                            16'h1000, 16'h1000, 16'h1000};
    logic [12:0] le [8] = '{13'h0000, 13'h0690, 13'h0CA8, 13'h0E88, 13'h01E0,
                            13'h03C0, 13'h05A0, 13'h0780};

    always #5 core_clk = ~core_clk;

    motor_drive_duty_lead_control #(.TICK_CYCLES(20'(TK))) dut_u (
        .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .hall_pin, .cur_zc_pin, .run_cmd, .op_phase, .motor_rpm, .out_current,
        .duty_cmd, .target_rpm_req, .duty_out, .lead_angle_q6, .cmd_freq_hz,
        .target_rpm, .soft_active, .lock_fault, .comm_150, .gate_drive);
    hall_motor_model hall_u (.core_clk, .spin, .hall_pin, .cur_zc_pin);

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic reg_write(input logic [4:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [4:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_duty;
        d0 = duty_out;
        for (int n = 0; n < 8 * TK && duty_out === d0; n++) cyc(1);
        d0 = duty_out;
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        wrap_up();
    end

    initial begin
        {rst_b, reg_wr, reg_rd, run_cmd, spin, reg_addr, reg_wdata} = '0;
        {motor_rpm, out_current, duty_cmd, target_rpm_req} = '0;
        op_phase = motor_drive_pkg::PH_STEADY;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (ra[i]) begin
            reg_read(ra[i], d);
            check(d, rv[i]);
        end
        for (int c = 0; c < 8; c++) begin
            reg_write(5'h04, 32'(c * 17));
            cyc(3);
            check(32'(gate_drive.source_ma_x10), 32'(src[c]));
            check(32'(gate_drive.sink_ma_x10), 32'(snk[c]));
        end
        spin <= 1'b1;
        foreach (lc[i]) begin
            @(posedge core_clk);
            motor_rpm <= lr[i];
            reg_write(5'h00, {27'h000_0013, lc[i]});
            cyc(4);
            check(32'(lead_angle_q6), 32'(le[i]));
        end
        check(32'(comm_150), 32'h0000_0001);
        reg_write(5'h00, 32'h0000_021F);
        motor_rpm <= 16'h0100;
        cyc(1000);
        check(32'(lead_angle_q6), 32'h0000_0780);
        @(posedge core_clk);
        motor_rpm <= 16'h1000;
        cyc(1000);
        check(32'(lead_angle_q6 > 13'h0780), 32'h0000_0001);
        reg_write(5'h08, 32'h0040_0004);
        @(posedge core_clk);
        run_cmd <= 1'b1;
        duty_cmd <= 9'h1FF;
        cyc(3);
        check(32'(soft_active), 32'h0000_0001);
        check(32'(cmd_freq_hz), 32'h0000_0001);
        for (int n = 0; n < 10 * TK && soft_active; n++) cyc(1);
        check(32'(soft_active), 32'h0000_0000);
        check(32'(lock_fault), 32'h0000_0000);
        reg_write(5'h00, 32'h0000_0120);
        wait_duty();
        cyc(4 * TK);
        check(32'(duty_out), 32'(d0 + 10'h001));
        reg_write(5'h00, 32'h0000_0020);
        wait_duty();
        cyc(TK);
        check(32'(duty_out), 32'(d0 + 10'h008));
        @(posedge core_clk);
        op_phase <= motor_drive_pkg::PH_ACCEL;
        reg_write(5'h00, 32'h0000_0820);
        wait_duty();
        cyc(4 * TK);
        check(32'(duty_out), 32'(d0 + 10'h008));
        reg_write(5'h04, 32'h0000_0100);
        target_rpm_req <= 16'h2710;
        cyc(3);
        check(32'(target_rpm), 32'h0000_2710);
        @(posedge core_clk);
        target_rpm_req <= 16'h2328;
        for (int n = 0; n < 2 * TK && target_rpm === 16'h2710; n++) cyc(1);
        check(32'(target_rpm), 32'h0000_2510);
        cyc(TK);
        check(32'(target_rpm), 32'h0000_2328);
        reg_write(5'h04, 32'h0000_0000);
        target_rpm_req <= 16'h07D0;
        run_cmd <= 1'b0;
        for (int n = 0; n < 2 * TK && target_rpm !== 16'h07D0; n++) cyc(1);
        cyc(4);
        check(32'(target_rpm), 32'h0000_07D0);
        check(32'(duty_out), 32'h0000_0000);
        reg_write(5'h08, 32'h0040_0100);
        spin <= 1'b0;
        reg_write(5'h0C, 32'h0000_0208);
        reg_write(5'h00, 32'h0000_02A0);
        run_cmd <= 1'b1;
        for (k = 0; k < 12 * TK && lock_fault !== 1'b1; k++) cyc(1);
        check(32'(lock_fault), 32'h0000_0001);
        check(32'(k > 8 * TK), 32'h0000_0001);
        wrap_up();
    end
endmodule
